// ### hdl/slot_formatter_pkg.sv
// Contract
// - frame is fifteen slots of 2560 chips
// - one power command field per slot
// - data spreading factor is 256 over 2^k
// - data slot carries 10 times 2^k bits
// - control channel always ten bits, factor 256
// - one control channel, any data channels
// - data and control code multiplexed on I/Q
// - slot format from configuration, reloadable
// - control field widths per slot format table
// - compressed variants A and B shift pilot bits
// - indicator formats unchanged only at fifteen slots
// - network decides indicator; device always supports it
// - indicator describes the concurrent data frame
// - site and diversity subfield widths bounded
// - unused feedback bits sent as one
// - two-bit feedback, diversity only: one then diversity
// - site subfield one bit when both active
// - pilot bits outside sync word sent as one
// - bit rates counted before spreading
// - raise is all ones, lower all zeros
// - preamble keeps format, indicator sent as zeros
package slot_formatter_pkg;

  // ==========================================================================
  // timebase
  localparam int unsigned CHIPS_PER_SLOT = 2560;
  localparam int unsigned SLOTS_PER_FRAME = 15;
  localparam int unsigned FRAME_TIME_MS = 10;
  localparam int unsigned CONTROL_BITS = 10;
  localparam int unsigned CONTROL_SF = 256;
  localparam int unsigned CHIPS_PER_CONTROL_BIT = CONTROL_SF;
  localparam int unsigned MAX_K = 6;
  localparam int unsigned DATA_BITS_BASE = 10;
  localparam int unsigned MIN_SLOTS_A = 10;
  localparam int unsigned MIN_SLOTS_B = 8;
  localparam int unsigned CONTROL_RATE_KBPS = 15;

  // ==========================================================================
  // slot format table: pilot, power, indicator, feedback widths
  localparam logic [2:0] NUM_FORMATS = 3'h6;
  localparam logic [3:0] PILOT_W [6] = '{4'h6, 4'h8, 4'h5, 4'h7, 4'h6, 4'h5};
  localparam logic [1:0] POWER_W [6] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1};
  localparam logic [2:0] IND_W [6] = '{3'h2, 3'h0, 3'h2, 3'h0, 3'h0, 3'h2};
  localparam logic [1:0] FB_W [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};

  typedef enum logic [3:0] {
    FIELD_PILOT = 4'h1,
    FIELD_IND = 4'h2,
    FIELD_FB = 4'h4,
    FIELD_POWER = 4'h8
  } field_type;

  typedef struct packed {
    logic [3:0] pilot;
    logic [2:0] ind;
    logic [1:0] fb;
    logic [1:0] power;
  } widths_type;

endpackage

// ### hdl/slot_timing_if.sv
`timescale 1ns/1ps
interface slot_timing_if;
  import slot_formatter_pkg::*;
  logic [11:0] chip;
  logic [3:0] slot;
  logic slot_start;
  logic frame_start;
  logic bit_start;
  logic [3:0] bit_index;
  modport source (output chip, slot, slot_start, frame_start, bit_start, bit_index);
  modport sink (input chip, slot, slot_start, frame_start, bit_start, bit_index);
endinterface

// ### hdl/slot_timebase.sv
`timescale 1ns/1ps
module slot_timebase
  import slot_formatter_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // control
  input wire logic restart_i,
  // timing out
  slot_timing_if.source tm
);

  logic [11:0] chip;
  logic [3:0] slot;

  // ==========================================================================
  // chip and slot counters
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      chip <= 12'h000;
      slot <= 4'h0;
    end
    else if (restart_i)
    begin
      chip <= 12'h000;
      slot <= 4'h0;
    end
    else if (chip == 12'(CHIPS_PER_SLOT - 1))
    begin
      chip <= 12'h000;
      slot <= (slot == 4'(SLOTS_PER_FRAME - 1)) ? 4'h0 : slot + 4'h1;
    end
    else
    begin
      chip <= chip + 12'h001;
    end
  end

  assign tm.chip = chip;
  assign tm.slot = slot;
  assign tm.slot_start = (chip == 12'h000);
  assign tm.frame_start = (chip == 12'h000) && (slot == 4'h0);
  assign tm.bit_start = (chip[7:0] == 8'h00);
  assign tm.bit_index = chip[11:8];

endmodule

// ### hdl/uplink_dedicated_slot_formatter.sv
`timescale 1ns/1ps
module uplink_dedicated_slot_formatter
  import slot_formatter_pkg::*;
#(
  parameter int unsigned NUM_DATA_CHANNELS = 1
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // configuration
  input wire logic restart_i,
  input wire logic config_load_i,
  input wire logic [2:0] slot_format_i,
  input wire logic [2:0] data_k_i,
  input wire logic [3:0] slots_per_frame_i,
  input wire logic indicator_enable_i,
  input wire logic [1:0] site_width_i,
  input wire logic diversity_enable_i,
  input wire logic preamble_i,
  input wire logic [NUM_DATA_CHANNELS-1:0] data_enable_i,
  // per-slot content
  input wire logic power_raise_i,
  input wire logic [3:0] indicator_bits_i,
  input wire logic [1:0] site_bits_i,
  input wire logic diversity_bit_i,
  input wire logic [7:0] sync_mask_i,
  input wire logic [7:0] sync_bits_i,
  // outputs
  output logic control_bit_o,
  output logic control_valid_o,
  output logic [NUM_DATA_CHANNELS-1:0] data_active_o,
  output logic [9:0] data_bits_per_slot_o,
  output logic [8:0] data_sf_o,
  output logic [3:0] slot_o,
  output logic slot_start_o,
  output logic frame_start_o,
  output logic [3:0] field_o,
  output logic config_error_o
);

  // ==========================================================================
  // chip timebase shared with the slot logic
  slot_timing_if tm ();

  slot_timebase u_timebase (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .restart_i(restart_i),
    .tm(tm)
  );

  // ==========================================================================
  // configuration registers
  logic [2:0] format;
  logic [2:0] k;
  logic [3:0] tx_slots;
  logic ind_on;
  logic [1:0] site_w;
  logic div_on;
  logic cfg_bad;
  logic cfg_ok;

  // ==========================================================================
  // configuration check

  function automatic logic config_valid(input logic [2:0] f, input logic [2:0] kk,
                                        input logic [3:0] n, input logic [1:0] sw,
                                        input logic dv);
    logic ok;
    ok = (f < NUM_FORMATS) && (kk <= 3'(MAX_K));
    ok = ok && (n >= 4'(MIN_SLOTS_B)) && (n <= 4'(SLOTS_PER_FRAME));
    ok = ok && (sw <= 2'h2);
    if (f < NUM_FORMATS)
      ok = ok && ({1'b0, sw} + {2'b00, dv} <= {1'b0, FB_W[f]});
    if (sw != 2'h0 && dv)
      ok = ok && (sw == 2'h1);
    return ok;
  endfunction

  // one decode shared by the error flag and the load path
  assign cfg_ok = config_valid(slot_format_i, data_k_i, slots_per_frame_i,
                               site_width_i, diversity_enable_i);

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      format <= 3'h1;
      k <= 3'h0;
      tx_slots <= 4'(SLOTS_PER_FRAME);
      ind_on <= 1'b0;
      site_w <= 2'h0;
      div_on <= 1'b0;
      cfg_bad <= 1'b0;
    end
    else if (config_load_i)
    begin
      // bad configurations are refused; the old format stays in force
      cfg_bad <= !cfg_ok;
      if (cfg_ok)
      begin
        format <= slot_format_i;
        k <= data_k_i;
        tx_slots <= slots_per_frame_i;
        ind_on <= indicator_enable_i;
        site_w <= site_width_i;
        div_on <= diversity_enable_i;
      end
    end
  end

  // ==========================================================================
  // effective field widths, including compressed variants
  function automatic widths_type field_widths(input logic [2:0] f, input logic [3:0] n);
    widths_type w;
    w.pilot = PILOT_W[f];
    w.ind = IND_W[f];
    w.fb = FB_W[f];
    w.power = POWER_W[f];
    if (IND_W[f] != 3'h0 && n < 4'(SLOTS_PER_FRAME))
    begin
      if (n >= 4'(MIN_SLOTS_A))
      begin
        w.pilot = w.pilot - 4'h1;
        w.ind = w.ind + 3'h1;
      end
      else
      begin
        w.pilot = w.pilot - 4'h2;
        w.ind = w.ind + 3'h2;
      end
    end
    return w;
  endfunction

  // ==========================================================================
  // field boundaries inside the slot
  widths_type w;
  logic [3:0] b;
  logic [3:0] end_pilot;
  logic [3:0] end_ind;
  logic [3:0] end_fb;
  logic [3:0] fb_pos;
  logic [3:0] ind_pos;
  field_type field;
  logic next_bit;

  always_comb
  begin
    w = field_widths(format, tx_slots);
    b = tm.bit_index;
    end_pilot = w.pilot;
    end_ind = end_pilot + {1'b0, w.ind};
    end_fb = end_ind + {2'b00, w.fb};
    fb_pos = b - end_ind;
    ind_pos = b - end_pilot;
    if (b < end_pilot)
      field = FIELD_PILOT;
    else if (b < end_ind)
      field = FIELD_IND;
    else if (b < end_fb)
      field = FIELD_FB;
    else
      field = FIELD_POWER;
  end

  // ==========================================================================
  // bit selection per field
  always_comb
  begin
    next_bit = 1'b1;
    case (field)
      FIELD_PILOT:
      begin
        // sync word positions from the pattern input, all others one
        if (b < 4'h8 && sync_mask_i[b[2:0]])
          next_bit = sync_bits_i[b[2:0]];
        else
          next_bit = 1'b1;
      end
      FIELD_IND:
      begin
        if (preamble_i || !ind_on)
          next_bit = 1'b0;
        else
          next_bit = indicator_bits_i[ind_pos[1:0]];
      end
      FIELD_FB:
      begin
        // site bits first, diversity last, remainder filled with one
        if (fb_pos < {2'b00, site_w})
          next_bit = site_bits_i[fb_pos[0]];
        else if (div_on && w.fb == 2'h2 && site_w == 2'h0)
          next_bit = (fb_pos == 4'h1) ? diversity_bit_i : 1'b1;
        else if (div_on && fb_pos == {2'b00, site_w})
          next_bit = diversity_bit_i;
        else
          next_bit = 1'b1;
      end
      FIELD_POWER:
        next_bit = power_raise_i;
      default:
        next_bit = 1'b1;
    endcase
  end

  // ==========================================================================
  // registered outputs
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      control_bit_o <= 1'b0;
      field_o <= 4'h0;
    end
    else
    begin
      control_bit_o <= next_bit;
      field_o <= field;
    end
  end

  // bit strobe, one per 256 chips
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      control_valid_o <= 1'b0;
    end
    else
    begin
      control_valid_o <= tm.bit_start;
    end
  end

  // ==========================================================================
  // slot and frame markers
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      slot_o <= 4'h0;
      slot_start_o <= 1'b0;
      frame_start_o <= 1'b0;
    end
    else
    begin
      slot_o <= tm.slot;
      slot_start_o <= tm.slot_start;
      frame_start_o <= tm.frame_start;
    end
  end

  // ==========================================================================
  // data channel size, counted before spreading
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      data_bits_per_slot_o <= 10'(DATA_BITS_BASE);
      data_sf_o <= 9'(CONTROL_SF);
    end
    else
    begin
      data_bits_per_slot_o <= 10'(DATA_BITS_BASE << k);
      data_sf_o <= 9'(CONTROL_SF >> k);
    end
  end

  // ==========================================================================
  // configuration status, held until the next load
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      config_error_o <= 1'b0;
    end
    else
    begin
      config_error_o <= cfg_bad;
    end
  end

  // ==========================================================================
  // data channel activity, one lane per code channel
  // data lanes run alongside the single control lane, not in time slots
  genvar ch;
  generate
    for (ch = 0; ch < NUM_DATA_CHANNELS; ch = ch + 1)
    begin : g_lane
      always_ff @(posedge clock_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          data_active_o[ch] <= 1'b0;
        end
        else
        begin
          data_active_o[ch] <= data_enable_i[ch] && !preamble_i;
        end
      end
    end
  endgenerate

endmodule

// ### dv/slot_word_sink.sv
`timescale 1ns/1ps
module slot_word_sink
  import slot_formatter_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // control channel stream
  input wire logic control_bit_i,
  input wire logic control_valid_i,
  input wire logic slot_start_i,
  // collected slot
  output logic [9:0] word_o,
  output logic word_ready_o
);
  // ==========
  // gathers one slot, first bit sent lands in bit 9
  logic [3:0] count;
  logic [9:0] next_word;
  // pilot bits come first, so sync positions sit at the top
  assign next_word = {slot_start_i ? 9'h000 : word_o[8:0], control_bit_i};
  always_ff @(posedge clock_i or negedge reset_n_i)
    if (!reset_n_i)
      count <= 4'h0;
    else if (control_valid_i)
      count <= slot_start_i ? 4'h1 : count + 4'h1;
  always_ff @(posedge clock_i)
    if (control_valid_i)
      word_o <= next_word;
  // ready only after ten bits of one slot
  always_ff @(posedge clock_i or negedge reset_n_i)
    if (!reset_n_i)
      word_ready_o <= 1'b0;
    else
      word_ready_o <= control_valid_i && !slot_start_i && count == 4'h9;
endmodule

// ### dv/slot_formatter_chk.sv
`timescale 1ns/1ps
module slot_formatter_chk
  import slot_formatter_pkg::*;
#(
  parameter int unsigned NUM_DATA_CHANNELS = 1
)
(
  // watched ports
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic restart_i,
  input wire logic config_load_i,
  input wire logic [2:0] slot_format_i,
  input wire logic preamble_i,
  input wire logic [NUM_DATA_CHANNELS-1:0] data_enable_i,
  input wire logic power_raise_i,
  input wire logic control_bit_o,
  input wire logic control_valid_o,
  input wire logic [NUM_DATA_CHANNELS-1:0] data_active_o,
  input wire logic [9:0] data_bits_per_slot_o,
  input wire logic [8:0] data_sf_o,
  input wire logic [3:0] slot_o,
  input wire logic slot_start_o,
  input wire logic frame_start_o,
  input wire logic [3:0] field_o,
  input wire logic config_error_o
);
  // ==========
  // bookkeeping; restart and the cycle after it are skipped as stale pulses may remain
  logic restart_d;
  logic [3:0] bit_count;
  logic [3:0] last_slot;
  always_ff @(posedge clock_i or negedge reset_n_i)
    if (!reset_n_i)
      restart_d <= 1'b0;
    else
      restart_d <= restart_i;
  always_ff @(posedge clock_i or negedge reset_n_i)
    if (!reset_n_i)
      bit_count <= 4'h0;
    else if (restart_i)
      bit_count <= 4'h0;
    else if (control_valid_o)
      bit_count <= (bit_count == 4'h9) ? 4'h0 : bit_count + 4'h1;
  always_ff @(posedge clock_i or negedge reset_n_i)
    if (!reset_n_i)
      last_slot <= 4'hE;
    else if (restart_i)
      last_slot <= 4'hE;
    else if (slot_start_o)
      last_slot <= slot_o;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i || restart_i || restart_d);
  sequence bit_edge;
    control_valid_o ##1 !control_valid_o;
  endsequence
  chk_bit_period:
    assert property (control_valid_o |=> !control_valid_o [*8] ##248 control_valid_o)
    else $error("control bit spacing wrong");
  chk_slot_marks:
    assert property (slot_start_o == (control_valid_o && bit_count == 4'h0))
    else $error("slot start not on tenth bit boundary");
  chk_frame_wrap:
    assert property (frame_start_o == (slot_start_o && slot_o == 4'h0))
    else $error("frame start mismatch");
  chk_slot_step:
    assert property (slot_start_o |-> slot_o == ((last_slot == 4'hE) ? 4'h0 : last_slot + 4'h1))
    else $error("slot number step wrong");
  chk_field_hold:
    assert property (bit_edge |-> $stable(field_o))
    else $error("field changed inside a bit");
  chk_pilot_first:
    assert property (slot_start_o |-> field_o == FIELD_PILOT)
    else $error("slot does not open with pilot");
  chk_power_last:
    assert property (control_valid_o && bit_count == 4'h9 |-> field_o == FIELD_POWER)
    else $error("slot does not close with power command");
  chk_power_value:
    assert property (control_valid_o && field_o == FIELD_POWER |-> control_bit_o == $past(power_raise_i))
    else $error("power command bit wrong");
  chk_rate_pair:
    assert property (data_sf_o * data_bits_per_slot_o == 2560)
    else $error("data rate and factor disagree");
  chk_active_map:
    assert property (1'b1 |=> data_active_o == ($past(preamble_i) ? '0 : $past(data_enable_i)))
    else $error("data channel activity wrong");
  chk_pre_indicator:
    assert property (control_valid_o && field_o == FIELD_IND && $past(preamble_i) |-> !control_bit_o)
    else $error("indicator not zero in preamble");
  chk_bad_format:
    assert property (config_load_i && slot_format_i > 3'h5 |=> config_error_o)
    else $error("bad format not refused");
endmodule

// ### dv/uplink_dedicated_slot_formatter_tb.sv
`timescale 1ns/1ps
module uplink_dedicated_slot_formatter_tb;
  import slot_formatter_pkg::*;
  // ==========
  // design hookup
  logic clock_i = 1'b0, reset_n_i = 1'b0, restart_i = 1'b0, config_load_i = 1'b0;
  logic indicator_enable_i = 1'b0, diversity_enable_i = 1'b0, preamble_i = 1'b0;
  logic power_raise_i = 1'b0, diversity_bit_i = 1'b0;
  logic [2:0] slot_format_i = 3'h1, data_k_i = 3'h0;
  logic [3:0] slots_per_frame_i = 4'hF, indicator_bits_i = 4'h0;
  logic [1:0] site_width_i = 2'h0, site_bits_i = 2'h0, data_enable_i = 2'h0;
  logic [7:0] sync_mask_i = 8'h00, sync_bits_i = 8'h00;
  logic control_bit_o, control_valid_o, slot_start_o, frame_start_o, config_error_o, ready;
  logic [1:0] data_active_o;
  logic [3:0] slot_o, field_o;
  logic [9:0] data_bits_per_slot_o, word;
  logic [8:0] data_sf_o;
  int fail_count = 0;
  int num_checks = 0;
  uplink_dedicated_slot_formatter #(.NUM_DATA_CHANNELS(2)) dut (.*);
  slot_word_sink sink (.clock_i(clock_i), .reset_n_i(reset_n_i), .control_bit_i(control_bit_o),
    .control_valid_i(control_valid_o), .slot_start_i(slot_start_o), .word_o(word),
    .word_ready_o(ready));
  initial
    forever #10 clock_i = ~clock_i;
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] want);
    num_checks++;
    if (seen !== want)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // bounded wait for a slot start or a collected slot
  task automatic await(input bit want_word);
    for (int n = 0; n < 3000; n++)
    begin
      tick(1);
      if ((want_word ? ready : slot_start_o) === 1'b1)
        return;
    end
    check("handshake wait", 10'h000, 10'h001);
  endtask
  // ==========
  // expected slot, first bit sent in bit 9
  function automatic logic [9:0] exp_word(int f, int s, int sw, bit dv, bit pre);
    int p, i, b, t, n;
    logic [9:0] w;
    b = FB_W[f];
    t = (IND_W[f] == 0 || s == 15) ? 0 : (s < 10) ? 2 : 1;
    p = PILOT_W[f] - t;
    i = IND_W[f] + t;
    n = 9;
    for (int j = 0; j < p; j++)
      w[n--] = sync_mask_i[j] ? sync_bits_i[j] : 1'b1;
    for (int j = 0; j < i; j++)
      w[n--] = indicator_enable_i && !pre && indicator_bits_i[j];
    for (int j = 0; j < b; j++)
      w[n--] = (j < sw) ? site_bits_i[j] : (dv && j == b - 1) ? diversity_bit_i : 1'b1;
    for (int j = 0; j < POWER_W[f]; j++)
      w[n--] = power_raise_i;
    return w;
  endfunction
  task automatic trial(input int f, input int s, input int sw, input bit dv, input bit pre);
    slot_format_i = 3'(f);
    slots_per_frame_i = 4'(s);
    site_width_i = 2'(sw);
    diversity_enable_i = dv;
    preamble_i = pre;
    data_k_i = 3'($urandom % 7);
    indicator_enable_i = 1'($urandom);
    indicator_bits_i = 4'($urandom);
    site_bits_i = 2'($urandom);
    diversity_bit_i = 1'($urandom);
    sync_mask_i = 8'($urandom);
    sync_bits_i = 8'($urandom);
    data_enable_i = 2'($urandom);
    power_raise_i = ~power_raise_i;
    config_load_i = 1'b1;
    tick(1);
    config_load_i = 1'b0;
    await(0);
    await(1);
    check("slot word", word, exp_word(f, s, sw, dv, pre));
    check("error flag", config_error_o, 1'b0);
    check("data bits", data_bits_per_slot_o, 10'(10 << data_k_i));
    check("data factor", {1'b0, data_sf_o}, 10'(256 >> data_k_i));
  endtask
  // ==========
  // main sequence
  initial
  begin
    void'($urandom(32'h24F7));
    tick(2);
    reset_n_i = 1'b1;
    tick(3);
    restart_i = 1'b1;
    tick(1);
    restart_i = 1'b0;
    await(0);
    check("frame start", frame_start_o, 1'b1);
    check("slot number", slot_o, 4'h0);
    for (int k = 0; k < 8; k++)
    begin
      data_k_i = 3'(k);
      config_load_i = 1'b1;
      tick(1);
      config_load_i = 1'b0;
      tick(1);
      check("k refusal", config_error_o, k == 7);
      check("data bits", data_bits_per_slot_o, 10'(10 << ((k > 6) ? 6 : k)));
    end
    for (int e = 0; e < 2; e++)
    begin
      data_k_i = 3'h0;
      slot_format_i = e ? 3'h4 : 3'h6;
      site_width_i = e ? 2'h2 : 2'h0;
      diversity_enable_i = 1'(e);
      config_load_i = 1'b1;
      tick(1);
      config_load_i = 1'b0;
      tick(1);
      check("config refusal", config_error_o, 1'b1);
    end
    trial(0, 8, 0, 0, 0);
    trial(5, 12, 1, 1, 0);
    trial(4, 15, 0, 1, 0);
    trial(2, 15, 1, 0, 1);
    trial(2, 9, 0, 1, 0);
    repeat (14)
    begin
      int f, b, sw;
      f = $urandom % 6;
      b = FB_W[f];
      sw = $urandom % (b + 1);
      trial(f, 8 + $urandom % 8, sw, (sw < b) && $urandom % 2, $urandom % 4 == 0);
    end
    give_verdict();
  end
  // cuts a hang short: the run needs about 51k cycles
  initial
  begin
    #2000000;
    fail_count++;
    give_verdict();
  end
endmodule
bind uplink_dedicated_slot_formatter slot_formatter_chk #(.NUM_DATA_CHANNELS(NUM_DATA_CHANNELS)) chk (.*);
